// ---- inc/exec_unit_map.svh ----
`ifndef EXEC_UNIT_MAP_SVH
`define EXEC_UNIT_MAP_SVH

// Register offsets on the plain register port (byte addresses)
`define OFF_WORKING     12'h000
`define OFF_FLAGS       12'h004
`define OFF_IRQ_CTRL    12'h008
`define OFF_PC_HIGH     12'h00c
`define OFF_PC          12'h010
`define OFF_INSTR       12'h014
`define OFF_STATE       12'h018
// File register window: base, and address bits that select it
`define OFF_FILE_BASE   4'h1
`define FILE_SEL_HI     11
`define FILE_SEL_LO     8

// Flags register fields
`define FLAG_CARRY      0
`define FLAG_HALF       1
// State register fields
`define STATE_BUSY      0
`define STATE_SKIP      1
// Instruction word fields
`define INSTR_OP_HI     2
`define INSTR_OP_LO     0
`define INSTR_DEST      3
`define INSTR_FILE_HI   9
`define INSTR_FILE_LO   4
`define INSTR_ADR_HI    18
`define INSTR_ADR_LO    10

// Reset values
`define RST_WORKING     8'h00
`define RST_PC          10'h000
`define RST_PC_HIGH     2'h0
`define RST_GIE         1'b0

// Decimal adjust constants
`define BCD_DIGIT_MAX   4'h9
`define BCD_BYTE_MAX    8'h99
`define BCD_LOW_FIX     8'h06
`define BCD_HIGH_FIX    8'h60

`endif

// ---- inc/exec_pkg.sv ----
package exec_pkg;

  // Operations the unit understands; code 7 is undefined
  typedef enum logic [2:0] {
    op_nop,
    op_add,
    decimal_adjust_op,
    decrement_skip_zero_op,
    irq_mask_all_op,
    irq_unmask_all_op,
    jump_immediate_op
  } op_t;

  // Register port request from software
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Decoded instruction word
  typedef struct packed {
    logic [8:0] target;
    logic [5:0] file;
    logic       dest;
    logic [2:0] op;
  } instr_t;

endpackage

// ---- rtl/exec_unit.sv ----
// Function
// - Decimal adjust working register, carry only, one cycle
// - Decrement file register 0..63, dest bit selects
// - Zero result discards next instruction as no-op
// - Mask instruction clears global enable, one cycle
// - Jump loads 9-bit operand, latch bit1 to pc9
// - Unmask instruction sets global enable, one cycle
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "exec_unit_map.svh"

module exec_unit (
  input wire logic core_clk,
  input wire logic rst,
  input exec_pkg::reg_req_t req,
  output logic [31:0] rdata,
  output logic global_irq_enable,
  output logic [9:0] pc,
  output logic busy
);
  import exec_pkg::*;

  // Checks below all run on the core clock and rest during reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Architectural state
  logic [7:0] wreg_q, wreg_d; // Working register
  logic carry_q, carry_d; // Carry flag
  logic half_q, half_d; // Half carry left by the last addition
  logic gie_q, gie_d; // Global interrupt enable
  logic [1:0] pchl_q, pchl_d; // High-address latch
  logic [9:0] pc_q, pc_d; // Program counter
  // Sequencing state
  logic skip_q, skip_d; // Next instruction becomes a no-op
  logic jbusy_q, jbusy_d; // Second cycle of a jump
  logic [8:0] jt_q, jt_d; // Jump operand held for the second cycle
  logic [31:0] rdata_q, rdata_d; // Read data, one cycle after strobe

  // File registers, no reset: contents are undefined at power-up
  logic [7:0] fmem [0:63];
  logic fwe; // File write enable
  logic [5:0] fidx; // File write index
  logic [7:0] fdata; // File write data

  // Decoded request
  instr_t instr;
  op_t op;
  logic issue; // Instruction accepted this cycle
  logic file_hit; // Access into the file window
  logic [5:0] bus_idx; // File index from bus address
  logic [7:0] fval; // Operand read from the file
  logic [7:0] dec_res; // Decremented operand
  logic [8:0] add_res; // Sum with carry out
  logic [4:0] add_lo; // Low nibble sum for half carry
  logic [7:0] daa_fix; // Decimal correction amount
  logic daa_carry; // Carry after correction
  logic [7:0] daa_res; // Corrected working register

  assign instr = instr_t'(req.wdata[`INSTR_ADR_HI:0]);
  assign op = op_t'(instr.op);
  // Writes to the instruction register while a jump completes are dropped
  assign issue = req.wr && (req.addr == `OFF_INSTR) && !jbusy_q;
  assign file_hit = (req.addr[`FILE_SEL_HI:`FILE_SEL_LO] == `OFF_FILE_BASE);
  assign bus_idx = req.addr[7:2];
  assign fval = fmem[instr.file];

  // Datapath for the arithmetic operations
  always_comb begin
    dec_res = fval - 8'h01;
    add_res = {1'b0, wreg_q} + {1'b0, fval};
    add_lo = {1'b0, wreg_q[3:0]} + {1'b0, fval[3:0]};
    // Correction uses the flags the preceding addition left behind
    daa_carry = carry_q || (wreg_q > `BCD_BYTE_MAX);
    daa_fix = 8'h00;
    if (half_q || (wreg_q[3:0] > `BCD_DIGIT_MAX)) begin
      daa_fix = daa_fix | `BCD_LOW_FIX;
    end
    if (daa_carry) begin
      daa_fix = daa_fix | `BCD_HIGH_FIX;
    end
    daa_res = wreg_q + daa_fix;
  end

  // Next state of the core and bus side effects
  always_comb begin
    wreg_d = wreg_q;
    carry_d = carry_q;
    half_d = half_q;
    gie_d = gie_q;
    pchl_d = pchl_q;
    pc_d = pc_q;
    skip_d = skip_q;
    jbusy_d = 1'b0;
    jt_d = jt_q;
    fwe = 1'b0;
    fidx = bus_idx;
    fdata = req.wdata[7:0];

    // Software writes to plain registers
    if (req.wr) begin
      if (file_hit) begin
        fwe = 1'b1;
      end else begin
        case (req.addr)
          `OFF_WORKING: wreg_d = req.wdata[7:0];
          `OFF_FLAGS: begin
            carry_d = req.wdata[`FLAG_CARRY];
            half_d = req.wdata[`FLAG_HALF];
          end
          `OFF_IRQ_CTRL: gie_d = req.wdata[0];
          `OFF_PC_HIGH: pchl_d = req.wdata[1:0];
          default: ;
        endcase
      end
    end

    // Instruction execution
    if (issue) begin
      pc_d = pc_q + 10'h001;
      if (skip_q) begin
        // Fetched instruction is thrown away; this cycle is a no-op
        skip_d = 1'b0;
      end else begin
        case (op)
          op_add: begin
            half_d = add_lo[4];
            carry_d = add_res[8];
            if (instr.dest) begin
              fwe = 1'b1;
              fidx = instr.file;
              fdata = add_res[7:0];
            end else begin
              wreg_d = add_res[7:0];
            end
          end
          decimal_adjust_op: begin
            // Only carry changes; half carry is left alone
            wreg_d = daa_res;
            carry_d = daa_carry;
          end
          decrement_skip_zero_op: begin
            if (instr.dest) begin
              // Result back to the file register
              fwe = 1'b1;
              fidx = instr.file;
              fdata = dec_res;
            end else begin
              wreg_d = dec_res;
            end
            // Arm the skip on a zero result so the next instruction is discarded
            skip_d = (dec_res == 8'h00);
          end
          irq_mask_all_op: gie_d = 1'b0;
          irq_unmask_all_op: gie_d = 1'b1;
          jump_immediate_op: begin
            // Operand held; program counter loads on the second cycle
            jbusy_d = 1'b1;
            jt_d = instr.target;
            pc_d = pc_q;
          end
          default: ; // No-op and undefined codes
        endcase
      end
    end

    // Second cycle of the jump builds the new program counter
    if (jbusy_q) begin
      pc_d = {pchl_q[1], jt_q};
    end
  end

  // Read path: data stand in the cycle after the strobe only
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (req.rd) begin
      if (file_hit) begin
        rdata_d = {24'h00_0000, fmem[bus_idx]};
      end else begin
        case (req.addr)
          `OFF_WORKING: rdata_d = {24'h00_0000, wreg_q};
          `OFF_FLAGS: rdata_d = {30'h0000_0000, half_q, carry_q};
          `OFF_IRQ_CTRL: rdata_d = {31'h0000_0000, gie_q};
          `OFF_PC_HIGH: rdata_d = {30'h0000_0000, pchl_q};
          `OFF_PC: rdata_d = {22'h00_0000, pc_q};
          `OFF_STATE: rdata_d = {30'h0000_0000, skip_q, jbusy_q};
          default: rdata_d = 32'h0000_0000; // Unmapped reads as zero
        endcase
      end
    end
  end

  // Register the core state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wreg_q <= `RST_WORKING;
      carry_q <= 1'b0;
      half_q <= 1'b0;
      gie_q <= `RST_GIE;
      pchl_q <= `RST_PC_HIGH;
      pc_q <= `RST_PC;
      skip_q <= 1'b0;
      jbusy_q <= 1'b0;
      jt_q <= 9'h000;
      rdata_q <= 32'h0000_0000;
    end else begin
      wreg_q <= wreg_d;
      carry_q <= carry_d;
      half_q <= half_d;
      gie_q <= gie_d;
      pchl_q <= pchl_d;
      pc_q <= pc_d;
      skip_q <= skip_d;
      jbusy_q <= jbusy_d;
      jt_q <= jt_d;
      rdata_q <= rdata_d;
    end
  end

  // File register storage; no reset keeps it a plain memory
  always_ff @(posedge core_clk) begin
    if (fwe) begin
      fmem[fidx] <= fdata;
    end
  end

  // Outputs straight from flip-flops
  assign rdata = rdata_q;
  assign global_irq_enable = gie_q;
  assign pc = pc_q;
  assign busy = jbusy_q;

  // Checks on the execution behaviour

  logic run; // Instruction really executes
  assign run = issue && !skip_q;

  // Arithmetic results
  daa_result_a: assert property (run && op == decimal_adjust_op |=>
    wreg_q == $past(daa_res) && carry_q == $past(daa_carry) && half_q == $past(half_q))
    else $error("decimal adjust result or flags wrong");

  dec_to_wreg_a: assert property (run && op == decrement_skip_zero_op && !instr.dest |=>
    wreg_q == 8'($past(fval) - 8'h01))
    else $error("decrement into working register wrong");

  dec_to_file_a: assert property (run && op == decrement_skip_zero_op && instr.dest |=>
    fmem[$past(instr.file)] == 8'($past(fval) - 8'h01) && wreg_q == $past(wreg_q))
    else $error("decrement into file register wrong");

  // Result to the working register leaves the file register alone
  file_hold_a: assert property (run && op == decrement_skip_zero_op && !instr.dest |=> fmem[$past(instr.file)] == $past(fval))
    else $error("file register changed by decrement into working register");

  // Skip sequencing
  skip_arm_a: assert property (run && op == decrement_skip_zero_op |=>
    skip_q == ($past(dec_res) == 8'h00))
    else $error("skip not armed on zero result");

  skip_nop_a: assert property (issue && skip_q |=>
    !skip_q && wreg_q == $past(wreg_q) && gie_q == $past(gie_q) && pc_q == $past(pc_q) + 10'h001)
    else $error("discarded instruction changed state");

  // Only the decrement can arm a skip
  skip_only_a: assert property (run && op != decrement_skip_zero_op |=> !skip_q)
    else $error("skip armed by another instruction");

  // Global enable
  mask_clear_a: assert property (run && op == irq_mask_all_op |=> !gie_q && carry_q == $past(carry_q))
    else $error("mask did not clear global enable");

  unmask_set_a: assert property (run && op == irq_unmask_all_op |=> gie_q)
    else $error("unmask did not set global enable");

  // Enable moves only by the mask pair or a direct write; a discarded one counts for nothing
  gie_hold_a: assert property (!(run && op inside {irq_mask_all_op, irq_unmask_all_op}) &&
    !(req.wr && req.addr == `OFF_IRQ_CTRL) |=> gie_q == $past(gie_q))
    else $error("global enable changed without cause");

  // One-cycle instructions finish at once and step the counter by one
  one_cycle_a: assert property (run &&
    op inside {decimal_adjust_op, irq_mask_all_op, irq_unmask_all_op} |=>
    !busy && pc_q == $past(pc_q) + 10'h001)
    else $error("one-cycle instruction did not finish in one cycle");

  // Jump sequencing: first cycle holds the counter
  jump_wait_a: assert property (run && op == jump_immediate_op |=> pc_q == $past(pc_q))
    else $error("counter moved in first jump cycle");

  // An instruction offered during the jump is dropped without effect
  busy_drop_a: assert property (req.wr && req.addr == `OFF_INSTR && jbusy_q |=>
    gie_q == $past(gie_q) && wreg_q == $past(wreg_q) && skip_q == $past(skip_q) && !busy)
    else $error("instruction taken while jump in progress");

  jump_pc_a: assert property (run && op == jump_immediate_op |=> busy ##1
    pc_q[8:0] == $past(jt_q) && pc_q[9] == $past(pchl_q[1]) && !busy)
    else $error("jump target not loaded on second cycle");

  daa_seen_c: cover property (run && op == decimal_adjust_op && daa_carry);
  skip_seen_c: cover property (run && op == decrement_skip_zero_op ##1 issue && skip_q);
  jump_seen_c: cover property (run && op == jump_immediate_op ##2 issue);
  mask_seen_c: cover property (run && op == irq_mask_all_op ##[1:20] run && op == irq_unmask_all_op);
  drop_seen_c: cover property (jbusy_q && req.wr && req.addr == `OFF_INSTR);
endmodule

// ---- verif/decimal_adjust_skip_branch_ops_test.sv ----
`timescale 1ns/1ps
`include "exec_unit_map.svh"

module decimal_adjust_skip_branch_ops_test;
  import exec_pkg::*;

  logic core_clk; // 10 MHz core clock
  logic rst; // Async reset, active high
  reg_req_t req; // Register port request
  logic [31:0] rdata; // Read data, one cycle after strobe
  logic global_irq_enable; // Global interrupt enable
  logic [9:0] pc; // Program counter
  logic busy; // Second cycle of a jump
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic rd_seen = 1'b0; // Read strobe taken at last edge
  logic [9:0] pc_e; // Expected program counter
  logic [31:0] seed = 32'hd1de; // Fixed seed
  int failures = 0;
  int compares = 0;

  exec_unit i_dut (
    .core_clk(core_clk),
    .rst(rst),
    .req(req),
    .rdata(rdata),
    .global_irq_enable(global_irq_enable),
    .pc(pc),
    .busy(busy)
  );

  // Clock generator
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Single comparison point
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task stop_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One bus cycle, launched just after a rising edge
  task bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  // Read; the watcher compares the answer one cycle later
  task rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, 1'b1, a, 32'h0);
    exp_q.push_back(e);
  endtask

  task idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      req <= '0;
    end
  endtask

  function automatic logic [31:0] word(op_t o, logic dd, logic [5:0] f, logic [8:0] t);
    return 32'(instr_t'{target: t, file: f, dest: dd, op: o});
  endfunction

  // Non-jump issue advances the expected pc by one
  task issue(input op_t o, input logic dd, input logic [5:0] f);
    wr(`OFF_INSTR, word(o, dd, f, 9'h0));
    pc_e = pc_e + 10'h1;
  endtask

  function automatic logic [11:0] faddr(logic [5:0] i);
    return {`OFF_FILE_BASE, i, 2'b00};
  endfunction

  function automatic logic [7:0] bcd(int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction

  // Watcher: read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        chk(rdata, 32'hffffffff);
      end else begin
        chk(rdata, exp_q.pop_front());
      end
    end
    rd_seen <= req.rd & ~rst;
  end

  // Hang guard
  initial begin
    #5000000;
    failures++;
    stop_test;
  end

  // Main sequence
  initial begin
    int x, y, s;
    logic [7:0] a, b, v;
    logic [5:0] idx;
    logic [8:0] t;
    rst = 1'b1;
    req = '0;
    pc_e = 10'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values, write-only and unmapped places read 0
    rd(`OFF_WORKING, 32'h0);
    rd(`OFF_FLAGS, 32'h0);
    rd(`OFF_IRQ_CTRL, 32'h0);
    rd(`OFF_PC, 32'h0);
    rd(`OFF_INSTR, 32'h0);
    rd(12'h020, 32'h0);
    // Unmask then mask, checked at the port; the mask is also read back from the register
    issue(irq_unmask_all_op, 1'b0, 6'h0);
    idle(1);
    #1 chk(32'(global_irq_enable), 32'h1);
    issue(irq_mask_all_op, 1'b0, 6'h0);
    idle(1);
    #1 chk(32'(global_irq_enable), 32'h0);
    rd(`OFF_IRQ_CTRL, 32'h0);
    // Decimal adjust straight after a packed-decimal add
    repeat (8) begin
      x = $unsigned($random(seed)) % 100;
      y = $unsigned($random(seed)) % 100;
      a = bcd(x);
      b = bcd(y);
      s = x + y;
      wr(`OFF_FLAGS, 32'h0);
      wr(`OFF_WORKING, 32'(a));
      wr(faddr(6'h05), 32'(b));
      issue(irq_mask_all_op, 1'b0, 6'h0);
      issue(op_add, 1'b0, 6'h05);
      issue(decimal_adjust_op, 1'b0, 6'h0);
      issue(irq_unmask_all_op, 1'b0, 6'h0);
      rd(`OFF_WORKING, 32'(bcd(s % 100)));
      rd(`OFF_FLAGS, {30'h0, (5'(a[3:0]) + 5'(b[3:0])) > 5'h0f, s > 99});
    end
    // Decrement without skip, both destinations
    for (int dd = 0; dd < 2; dd++) begin
      idx = 6'($random(seed));
      v = 8'($unsigned($random(seed)) % 254 + 2);
      wr(`OFF_WORKING, 32'h0);
      wr(faddr(idx), 32'(v));
      issue(decrement_skip_zero_op, 1'(dd), idx);
      rd(`OFF_WORKING, (dd == 1) ? 32'h0 : 32'(v - 8'h1));
      rd(faddr(idx), (dd == 1) ? 32'(v - 8'h1) : 32'(v));
      rd(`OFF_STATE, 32'h0);
    end
    // Zero result discards the next issue; enable off so the lost unmask shows
    issue(irq_mask_all_op, 1'b0, 6'h0);
    wr(faddr(6'h3f), 32'h1);
    issue(decrement_skip_zero_op, 1'b1, 6'h3f);
    rd(`OFF_STATE, 32'h2);
    rd(faddr(6'h3f), 32'h0);
    issue(irq_unmask_all_op, 1'b0, 6'h0);
    rd(`OFF_IRQ_CTRL, 32'h0);
    rd(`OFF_STATE, 32'h0);
    issue(irq_unmask_all_op, 1'b0, 6'h0);
    rd(`OFF_IRQ_CTRL, 32'h1);
    rd(`OFF_PC, 32'(pc_e));
    // Jump with every latch value; an issue while busy is dropped
    for (int l = 0; l < 4; l++) begin
      t = 9'($random(seed));
      wr(`OFF_PC_HIGH, 32'(l));
      wr(`OFF_INSTR, word(jump_immediate_op, 1'b0, 6'h0, t));
      bus(1'b1, 1'b0, `OFF_INSTR, word(irq_mask_all_op, 1'b0, 6'h0, 9'h0));
      #1 chk(32'(busy), 32'h1);
      chk(32'(pc), 32'(pc_e));
      idle(1);
      pc_e = {1'(l >> 1), t};
      #1 chk(32'(busy), 32'h0);
      chk(32'(pc), 32'(pc_e));
      rd(`OFF_IRQ_CTRL, 32'h1);
    end
    rd(`OFF_PC, 32'(pc_e));
    idle(3);
    chk(32'(exp_q.size()), 32'h0);
    stop_test;
  end
endmodule
